// File: design/afd_diag_regs.sv
// fault-diagnostic register bank of a mono class-d amplifier behind a serial slave
`timescale 1ns/1ns
`include "afd_regs.svh"
module afd_diag_regs (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic gpioPinIn,
    output logic gpioPinOut,
    output logic gpioPinOe,
    input wire afd_pkg::afd_short_t shortIn,
    input wire logic otpIn,
    output logic ampOn,
    output logic shortFault,
    output logic overTemp
);

    // assertion clock and reset for every check in this module
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // synchronised pins
    logic sclS; // serial clock
    logic sdaS; // serial data
    logic pinS; // multi-purpose pin level
    logic otpS; // overtemperature detector
    afd_pkg::afd_short_t shortS; // short detectors
    logic shortAny; // any short condition

    afd_sync #(
        .WIDTH(7)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din({shortIn, otpIn, gpioPinIn, sdaIn, sclIn}),
        .dout({shortS, otpS, pinS, sdaS, sclS})
    );

    assign shortAny = shortS.outToOut | shortS.outToGnd | shortS.outToPwr;

    // serial slave state
    afd_pkg::afd_state_t state_reg, state_next;
    logic sclPrev_reg, sclPrev_next; // last serial clock
    logic sdaPrev_reg, sdaPrev_next; // last serial data
    logic [3:0] cnt_reg, cnt_next; // bits moved in this byte
    logic [7:0] shift_reg, shift_next; // receive shifter
    logic [7:0] tx_reg, tx_next; // transmit shifter
    logic [7:0] ptr_reg, ptr_next; // register pointer, auto-incrementing
    logic rw_reg, rw_next; // read request
    logic ptrPhase_reg, ptrPhase_next; // next write byte is the pointer
    logic nack_reg, nack_next; // master refused more data
    logic sdaOe_reg, sdaOe_next; // pulling data low
    // register bank state
    logic [7:0] page_reg, page_next; // selected page
    logic [7:0] amp_reg, amp_next; // amplifier control byte
    logic [7:0] gpio_reg, gpio_next; // pin control byte
    logic latch_reg, latch_next; // short fault seen since reset
    logic ampOn_reg, ampOn_next; // amplifier stage enable
    logic gpOut_reg, gpOut_next; // pin output level
    logic gpOe_reg, gpOe_next; // pin output enable
    logic otp_reg, otp_next; // overtemperature out
    // bus events
    logic start; // start condition
    logic stop; // stop condition
    logic sclRise;
    logic sclFall;
    logic wrEn; // one-cycle register write strobe
    logic softRst; // software reset write
    logic [7:0] rdData; // byte at the pointer
    logic [3:0] pinMode; // pin mode field
    logic pinInMode; // pin in general input mode

    assign start = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
    assign stop = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;
    assign sclRise = sclS & ~sclPrev_reg;
    assign sclFall = ~sclS & sclPrev_reg;
    assign pinMode = gpio_reg[`AFD_MODE_HI:`AFD_MODE_LO];
    assign pinInMode = (pinMode == `AFD_MODE_GPIN);

    // read mux, one byte per register
    always_comb
    begin
        rdData = 8'h00;
        if (ptr_reg == `AFD_REG_PAGE)
        begin
            rdData = page_reg;
        end
        else if (page_reg == `AFD_PAGE0)
        begin
            if (ptr_reg == `AFD_REG_AMP)
            begin
                rdData[`AFD_BIT_OTP] = otpS;
            end
            else if (ptr_reg == `AFD_REG_GPIO)
            begin
                rdData = gpio_reg;
                rdData[`AFD_BIT_PIN] = pinInMode & pinS;
            end
        end
        else if (page_reg == `AFD_PAGE1 && ptr_reg == `AFD_REG_AMP)
        begin
            rdData = amp_reg;
        end
    end

    // serial slave next state; runs whatever the mute state is
    always_comb
    begin
        state_next = state_reg;
        sclPrev_next = sclS;
        sdaPrev_next = sdaS;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        ptrPhase_next = ptrPhase_reg;
        nack_next = nack_reg;
        sdaOe_next = sdaOe_reg;
        wrEn = 1'b0;
        if (start)
        begin
            // (re)start: expect the address byte
            state_next = afd_pkg::ST_ADDR;
            cnt_next = 4'h0;
            sdaOe_next = 1'b0;
        end
        else if (stop)
        begin
            state_next = afd_pkg::ST_IDLE;
            sdaOe_next = 1'b0;
        end
        else
        begin
            unique case (state_reg)
                afd_pkg::ST_IDLE:
                begin
                    state_next = afd_pkg::ST_IDLE;
                end
                afd_pkg::ST_ADDR:
                begin
                    if (sclRise)
                    begin
                        shift_next = {shift_reg[6:0], sdaS};
                        cnt_next = cnt_reg + 4'h1;
                    end
                    else if (sclFall && cnt_reg == `AFD_BYTE_BITS)
                    begin
                        cnt_next = 4'h0;
                        if (shift_reg[7:1] == `AFD_I2C_ADDR)
                        begin
                            state_next = afd_pkg::ST_ACKA;
                            rw_next = shift_reg[0];
                            sdaOe_next = 1'b1;
                        end
                        else
                        begin
                            state_next = afd_pkg::ST_IDLE;
                        end
                    end
                end
                afd_pkg::ST_ACKA:
                begin
                    if (sclFall && rw_reg)
                    begin
                        // first read byte, msb driven now
                        state_next = afd_pkg::ST_READ;
                        tx_next = rdData;
                        sdaOe_next = ~rdData[7];
                        cnt_next = 4'h1;
                    end
                    else if (sclFall)
                    begin
                        state_next = afd_pkg::ST_WRITE;
                        sdaOe_next = 1'b0;
                        ptrPhase_next = 1'b1;
                    end
                end
                afd_pkg::ST_WRITE:
                begin
                    if (sclRise)
                    begin
                        shift_next = {shift_reg[6:0], sdaS};
                        cnt_next = cnt_reg + 4'h1;
                    end
                    else if (sclFall && cnt_reg == `AFD_BYTE_BITS)
                    begin
                        cnt_next = 4'h0;
                        state_next = afd_pkg::ST_ACKW;
                        sdaOe_next = 1'b1;
                        ptrPhase_next = 1'b0;
                        if (ptrPhase_reg)
                        begin
                            ptr_next = shift_reg;
                        end
                        else
                        begin
                            wrEn = 1'b1;
                            ptr_next = ptr_reg + `AFD_PTR_STEP;
                        end
                    end
                end
                afd_pkg::ST_ACKW:
                begin
                    if (sclFall)
                    begin
                        state_next = afd_pkg::ST_WRITE;
                        sdaOe_next = 1'b0;
                    end
                end
                afd_pkg::ST_READ:
                begin
                    if (sclFall && cnt_reg == `AFD_BYTE_BITS)
                    begin
                        // byte done, release for the master's ack
                        state_next = afd_pkg::ST_ACKR;
                        sdaOe_next = 1'b0;
                        ptr_next = ptr_reg + `AFD_PTR_STEP;
                        cnt_next = 4'h0;
                    end
                    else if (sclFall)
                    begin
                        sdaOe_next = ~tx_reg[6];
                        tx_next = {tx_reg[6:0], 1'b0};
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
                afd_pkg::ST_ACKR:
                begin
                    if (sclRise)
                    begin
                        nack_next = sdaS;
                    end
                    else if (sclFall && nack_reg)
                    begin
                        state_next = afd_pkg::ST_IDLE;
                    end
                    else if (sclFall)
                    begin
                        state_next = afd_pkg::ST_READ;
                        tx_next = rdData;
                        sdaOe_next = ~rdData[7];
                        cnt_next = 4'h1;
                    end
                end
                default:
                begin
                    state_next = afd_pkg::ST_IDLE;
                    sdaOe_next = 1'b0;
                end
            endcase
        end
    end

    assign softRst = wrEn && page_reg == `AFD_PAGE0 && ptr_reg == `AFD_REG_SWRST
        && shift_reg[`AFD_BIT_SWRST];

    // register bank next state
    always_comb
    begin
        page_next = page_reg;
        amp_next = amp_reg;
        gpio_next = gpio_reg;
        latch_next = latch_reg;
        if (softRst)
        begin
            // software reset: back to defaults, fault released unless a short is still present
            page_next = `AFD_PAGE_RST;
            amp_next = `AFD_AMP_RST;
            gpio_next = `AFD_GPIO_RST;
            latch_next = 1'b0;
        end
        else if (wrEn && ptr_reg == `AFD_REG_PAGE)
        begin
            page_next = shift_reg;
        end
        else if (wrEn && page_reg == `AFD_PAGE1 && ptr_reg == `AFD_REG_AMP)
        begin
            amp_next = shift_reg;
        end
        else if (wrEn && page_reg == `AFD_PAGE0 && ptr_reg == `AFD_REG_GPIO)
        begin
            gpio_next = shift_reg;
        end
        if (shortAny)
        begin
            latch_next = 1'b1;
        end
        if (latch_next)
        begin
            // fault wins over any write of the run bit
            amp_next[`AFD_BIT_RUN] = 1'b0;
        end
        ampOn_next = amp_reg[`AFD_BIT_RUN] & ~latch_reg & ~otpS;
        gpOut_next = gpio_reg[`AFD_BIT_GPOUT];
        gpOe_next = (pinMode == `AFD_MODE_GPOUT);
        otp_next = otpS;
    end

    // all state registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= afd_pkg::ST_IDLE;
            sclPrev_reg <= 1'b0;
            sdaPrev_reg <= 1'b0;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            ptrPhase_reg <= 1'b0;
            nack_reg <= 1'b0;
            sdaOe_reg <= 1'b0;
            page_reg <= `AFD_PAGE_RST;
            amp_reg <= `AFD_AMP_RST;
            gpio_reg <= `AFD_GPIO_RST;
            latch_reg <= 1'b0;
            ampOn_reg <= 1'b0;
            gpOut_reg <= 1'b0;
            gpOe_reg <= 1'b0;
            otp_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            sclPrev_reg <= sclPrev_next;
            sdaPrev_reg <= sdaPrev_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            ptrPhase_reg <= ptrPhase_next;
            nack_reg <= nack_next;
            sdaOe_reg <= sdaOe_next;
            page_reg <= page_next;
            amp_reg <= amp_next;
            gpio_reg <= gpio_next;
            latch_reg <= latch_next;
            ampOn_reg <= ampOn_next;
            gpOut_reg <= gpOut_next;
            gpOe_reg <= gpOe_next;
            otp_reg <= otp_next;
        end
    end

    // open-drain data: only ever pulls low
    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_reg;
    assign gpioPinOut = gpOut_reg;
    assign gpioPinOe = gpOe_reg;
    assign ampOn = ampOn_reg;
    assign shortFault = latch_reg;
    assign overTemp = otp_reg;

    // checks on the bank

    a_short_clears_run: assert property (shortAny |=> !amp_reg[`AFD_BIT_RUN] ##1 !ampOn_reg)
        else $error("short did not clear run and stop amplifier");
    a_short_latch_holds: assert property (latch_reg && !softRst |=> latch_reg)
        else $error("short indication dropped without reset");
    a_run_write_blocked: assert property (latch_reg && !softRst |=> !amp_reg[`AFD_BIT_RUN])
        else $error("run bit restored while short latched");
    a_mute_stops_amp: assert property (!amp_reg[`AFD_BIT_RUN] |=> !ampOn_reg)
        else $error("amplifier on while run bit low");
    a_otp_stops_amp: assert property (otpS |=> !ampOn_reg && overTemp)
        else $error("amplifier on during overtemperature");
    a_run_resumes: assert property (amp_reg[`AFD_BIT_RUN] && !latch_reg && !otpS |=> ampOn_reg)
        else $error("amplifier did not resume");
    a_page_stable: assert property (!(wrEn && ptr_reg == `AFD_REG_PAGE) && !softRst
        |=> $stable(page_reg))
        else $error("page changed without a page write");
    a_page_write: assert property (wrEn && ptr_reg == `AFD_REG_PAGE |=> page_reg == $past(shift_reg))
        else $error("page write not taken");
    a_pin_readback: assert property (state_reg == afd_pkg::ST_ACKA && rw_reg
        && sclFall && !start && !stop && pinInMode && page_reg == `AFD_PAGE0
        && ptr_reg == `AFD_REG_GPIO |=> tx_reg[`AFD_BIT_PIN] == $past(pinS))
        else $error("pin level not loaded for a read in input mode");
    a_ack_address: assert property (state_reg == afd_pkg::ST_ADDR && sclFall && !start && !stop
        && cnt_reg == `AFD_BYTE_BITS && shift_reg[7:1] == `AFD_I2C_ADDR |=> sdaOe_reg)
        else $error("own address not acknowledged");

    c_short_seen: cover property (shortAny ##1 latch_reg);
    c_mute_unmute: cover property (ampOn_reg ##[1:1000] !ampOn_reg ##[1:1000] ampOn_reg);
    c_read_byte: cover property (state_reg == afd_pkg::ST_READ ##[1:1000] state_reg == afd_pkg::ST_ACKR);
    c_pin_input: cover property (pinInMode && pinS);

endmodule // afd_diag_regs

// File: design/afd_pkg.sv
// types shared by the fault-diagnostic register bank
package afd_pkg;

    // serial slave states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ACKA = 7'h04,
        ST_WRITE = 7'h08,
        ST_ACKW = 7'h10,
        ST_READ = 7'h20,
        ST_ACKR = 7'h40
    } afd_state_t;

    // short detector levels from the output stage
    typedef struct packed {
        logic outToOut; // the two speaker outputs shorted together
        logic outToGnd; // either output shorted to ground
        logic outToPwr; // either output shorted to the supply rail
    } afd_short_t;

endpackage

// File: design/afd_regs.svh
// register offsets, field positions and reset values of the fault-diagnostic register bank
`ifndef AFD_REGS_SVH
`define AFD_REGS_SVH

// fixed bus target address, seven bits (0x30 as an 8-bit write address)
`define AFD_I2C_ADDR 7'h18
// register offsets within a page
`define AFD_REG_PAGE 8'h00
`define AFD_REG_SWRST 8'h01
`define AFD_REG_AMP 8'h2d
`define AFD_REG_GPIO 8'h34
// page select values
`define AFD_PAGE0 8'h00
`define AFD_PAGE1 8'h01
// field positions
`define AFD_BIT_RUN 1
`define AFD_BIT_OTP 7
`define AFD_BIT_PIN 1
`define AFD_BIT_GPOUT 0
`define AFD_BIT_SWRST 0
`define AFD_MODE_HI 5
`define AFD_MODE_LO 2
// pin mode codes
`define AFD_MODE_GPIN 4'h2
`define AFD_MODE_GPOUT 4'h3
// reset values
`define AFD_PAGE_RST 8'h00
`define AFD_AMP_RST 8'h00
`define AFD_GPIO_RST 8'h00
// bits per byte on the serial link, pointer step
`define AFD_BYTE_BITS 4'h8
`define AFD_PTR_STEP 8'h01

`endif

// File: design/afd_sync.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module afd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_reg; // first stage, read only by the second
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg; // second stage
    logic [WIDTH-1:0] sync_next;

    // next values: shift the pin through two stages
    always_comb
    begin
        meta_next = din;
        sync_next = meta_reg;
    end

    // stage registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign dout = sync_reg;

endmodule // afd_sync

// File: testbench/afd_i2c_host.sv
// serial bus master model standing in for the host controller
`timescale 1ns/1ns
module afd_i2c_host #(
    parameter int QTR = 5
) (
    input wire logic sys_clk,
    input wire logic sdaLine,
    output logic sclOut,
    output logic sdaLow
);
    // bus idles released, clock high
    initial
    begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end

    // one quarter bit time, moves land on falling edges
    task automatic qwait();
        repeat (QTR) @(negedge sys_clk);
    endtask

    // start or repeated start: data falls while clock high
    task automatic start_cond();
        sdaLow = 1'b0;
        qwait();
        sclOut = 1'b1;
        qwait();
        sdaLow = 1'b1;
        qwait();
        sclOut = 1'b0;
        qwait();
    endtask

    // stop: data rises while clock high
    task automatic stop_cond();
        sdaLow = 1'b1;
        qwait();
        sclOut = 1'b1;
        qwait();
        sdaLow = 1'b0;
        qwait();
    endtask

    // send one bit, data held over the whole high phase
    task automatic bit_tx(input logic b);
        sdaLow = ~b;
        qwait();
        sclOut = 1'b1;
        qwait();
        qwait();
        sclOut = 1'b0;
        qwait();
    endtask

    // release data and sample it mid high phase
    task automatic bit_rx(output logic b);
        sdaLow = 1'b0;
        qwait();
        sclOut = 1'b1;
        qwait();
        b = sdaLine;
        qwait();
        sclOut = 1'b0;
        qwait();
    endtask

    // byte out msb first, then the target's acknowledge
    task automatic byte_tx(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            bit_tx(v[i]);
        bit_rx(b);
        ack = ~b;
    endtask

    // byte in msb first, then ack or closing nack
    task automatic byte_rx(input logic last, output logic [7:0] v);
        for (int i = 7; i >= 0; i--)
            bit_rx(v[i]);
        bit_tx(last);
    endtask

    // pointer then one data byte; ack is the and of all byte acks
    task automatic wr_reg(input logic [6:0] adr, input logic [7:0] ptr, input logic [7:0] dat,
        output logic ack);
        logic a0, a1, a2;
        start_cond();
        byte_tx({adr, 1'b0}, a0);
        byte_tx(ptr, a1);
        byte_tx(dat, a2);
        stop_cond();
        ack = a0 & a1 & a2;
    endtask

    // pointer write, repeated start, one byte read and nack
    task automatic rd_reg(input logic [6:0] adr, input logic [7:0] ptr, output logic [7:0] dat);
        logic a;
        start_cond();
        byte_tx({adr, 1'b0}, a);
        byte_tx(ptr, a);
        start_cond();
        byte_tx({adr, 1'b1}, a);
        byte_rx(1'b1, dat);
        stop_cond();
    endtask
endmodule // afd_i2c_host

// File: testbench/amp_fault_diag_regs_test.sv
// self-checking bench for the fault-diagnostic register bank
`timescale 1ns/1ns
`include "afd_regs.svh"
module amp_fault_diag_regs_test;
    logic sys_clk = 1'b0; // 25 MHz system clock
    logic rst = 1'b1; // async reset, active high
    logic sclIn, sdaOut, sdaOe, sdaLow, sdaLine;
    logic gpioPinIn = 1'b1; // diagnostic comparator level
    logic gpioPinOut, gpioPinOe, otpIn, ampOn, shortFault, overTemp;
    afd_pkg::afd_short_t shortIn; // short detector levels
    int failures = 0;
    int compares = 0;
    logic ack;
    logic [7:0] rdv;

    always #20 sys_clk = ~sys_clk;
    // open drain wire with pull-up
    assign sdaLine = (sdaOe | sdaLow) ? 1'b0 : 1'b1;

    afd_diag_regs afd_diag_regs_i (.sys_clk(sys_clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .gpioPinIn(gpioPinIn), .gpioPinOut(gpioPinOut),
        .gpioPinOe(gpioPinOe), .shortIn(shortIn), .otpIn(otpIn), .ampOn(ampOn),
        .shortFault(shortFault), .overTemp(overTemp));
    afd_i2c_host afd_i2c_host_i (.sys_clk(sys_clk), .sdaLine(sdaLine), .sclOut(sclIn),
        .sdaLow(sdaLow));

    // compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // register write at the device address, acknowledge expected
    task automatic wr(input logic [7:0] ptr, input logic [7:0] dat);
        afd_i2c_host_i.wr_reg(`AFD_I2C_ADDR, ptr, dat, ack);
        check("write ack", {7'h00, ack}, 8'h01);
    endtask

    // register read compared with the expected byte
    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
        afd_i2c_host_i.rd_reg(`AFD_I2C_ADDR, ptr, rdv);
        check("read byte", rdv, exp);
    endtask

    // let synchronisers and latches settle
    task automatic settle();
        repeat (10) @(negedge sys_clk);
    endtask

    // full initialisation: reset, page one, run bit set
    task automatic init_seq();
        wr(`AFD_REG_PAGE, `AFD_PAGE0);
        wr(`AFD_REG_SWRST, 8'h01);
        wr(`AFD_REG_PAGE, `AFD_PAGE1);
        wr(`AFD_REG_AMP, 8'h02);
        check("ampOn", {7'h00, ampOn}, 8'h01);
        check("shortFault", {7'h00, shortFault}, 8'h00);
    endtask

    // verdict and end of run
    task automatic end_sim();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // bound on the whole run
    initial
    begin
        repeat (100000) @(posedge sys_clk);
        failures++;
        end_sim();
    end

    // main sequence
    initial
    begin
        shortIn = 3'h0;
        otpIn = 1'b0;
        repeat (5) @(negedge sys_clk);
        check("ampOn in reset", {7'h00, ampOn}, 8'h00);
        rst = 1'b0;
        settle();
        check("sdaOut", {7'h00, sdaOut}, 8'h00);
        rd(`AFD_REG_PAGE, 8'h00);
        init_seq();
        rd(`AFD_REG_AMP, 8'h02);
        // wrong address is not acknowledged and changes nothing
        afd_i2c_host_i.wr_reg(7'h19, `AFD_REG_AMP, 8'h00, ack);
        check("foreign ack", {7'h00, ack}, 8'h00);
        check("ampOn kept", {7'h00, ampOn}, 8'h01);
        rd(8'h50, 8'h00);
        // overtemperature stops and resumes without reset
        wr(`AFD_REG_PAGE, `AFD_PAGE0);
        otpIn = 1'b1;
        settle();
        check("ampOn hot", {7'h00, ampOn}, 8'h00);
        check("overTemp", {7'h00, overTemp}, 8'h01);
        wr(`AFD_REG_AMP, 8'hff);
        rd(`AFD_REG_AMP, 8'h80);
        otpIn = 1'b0;
        settle();
        check("ampOn cool", {7'h00, ampOn}, 8'h01);
        check("overTemp cool", {7'h00, overTemp}, 8'h00);
        rd(`AFD_REG_AMP, 8'h00);
        // open-load check: confirm no short, mute, read pin
        wr(`AFD_REG_PAGE, `AFD_PAGE1);
        rd(`AFD_REG_AMP, 8'h02);
        wr(`AFD_REG_AMP, 8'h00);
        check("ampOn muted", {7'h00, ampOn}, 8'h00);
        rd(`AFD_REG_PAGE, `AFD_PAGE1);
        rd(`AFD_REG_AMP, 8'h00);
        wr(`AFD_REG_PAGE, `AFD_PAGE0);
        wr(`AFD_REG_GPIO, 8'h08);
        check("gpioPinOe input", {7'h00, gpioPinOe}, 8'h00);
        settle();
        rd(`AFD_REG_GPIO, 8'h0a);
        gpioPinIn = 1'b0;
        settle();
        rd(`AFD_REG_GPIO, 8'h08);
        wr(`AFD_REG_GPIO, 8'h0d);
        check("gpioPinOe output", {7'h00, gpioPinOe}, 8'h01);
        check("gpioPinOut", {7'h00, gpioPinOut}, 8'h01);
        rd(`AFD_REG_GPIO, 8'h0d);
        wr(`AFD_REG_GPIO, 8'h00);
        wr(`AFD_REG_PAGE, `AFD_PAGE1);
        wr(`AFD_REG_AMP, 8'h02);
        check("ampOn resumed", {7'h00, ampOn}, 8'h01);
        // each short kind latches, holds and needs reinitialisation
        for (int k = 0; k < 3; k++)
        begin
            shortIn = afd_pkg::afd_short_t'(3'h1 << k);
            settle();
            check("ampOn short", {7'h00, ampOn}, 8'h00);
            check("shortFault", {7'h00, shortFault}, 8'h01);
            shortIn = 3'h0;
            settle();
            rd(`AFD_REG_AMP, 8'h00);
            wr(`AFD_REG_AMP, 8'h02);
            check("ampOn rewrite", {7'h00, ampOn}, 8'h00);
            rd(`AFD_REG_AMP, 8'h00);
            init_seq();
        end
        end_sim();
    end
endmodule // amp_fault_diag_regs_test
